/* design/dsr_pkg.sv */
package dsr_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int DSR_DATA_W = 8;
  localparam int DSR_ADDR_W = 8;
  localparam int DSR_FIELD_W = 2;
  localparam int DSR_OUT_COUNT = 20;
  localparam int DSR_OUT_REGS = 5;
  localparam int DSR_FIELDS_PER_REG = 4;
  localparam int DSR_DFB_FIRST = 8;
  localparam int DSR_DFB_LAST = 13;
  localparam int DSR_IGN_COUNT = 4;
  localparam int DSR_SYNC_PINS = 3;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DSR_OFF_SENSOR_FLAGS = 8'h22;
  localparam logic [7:0] DSR_OFF_SENSOR_MEAS = 8'h23;
  localparam logic [7:0] DSR_OFF_COMM_FAULTS = 8'h24;
  localparam logic [7:0] DSR_OFF_OUT_1_4 = 8'h25;
  localparam logic [7:0] DSR_OFF_OUT_5_8 = 8'h26;
  localparam logic [7:0] DSR_OFF_OUT_9_12 = 8'h27;
  localparam logic [7:0] DSR_OFF_OUT_13_16 = 8'h28;
  localparam logic [7:0] DSR_OFF_OUT_17_20 = 8'h29;
  localparam logic [7:0] DSR_OFF_OUT_OV = 8'h2a;
  localparam logic [7:0] DSR_OFF_BRIDGE_OFF = 8'h2b;
  localparam logic [7:0] DSR_OFF_BRIDGE_FAULT = 8'h2c;
  localparam logic [7:0] DSR_OFF_IGN_DIAG = 8'h2d;
  localparam logic [7:0] DSR_OFF_WD_FAULTS = 8'h2e;
  localparam logic [7:0] DSR_OFF_EOT_LOW = 8'h31;
  localparam logic [7:0] DSR_OFF_EOT_MID = 8'h32;
  localparam logic [7:0] DSR_OFF_EOT_HIGH = 8'h33;
  localparam logic [7:0] DSR_OFF_OP_STATE = 8'h34;
  localparam logic [7:0] DSR_OFF_RESET_CAUSE = 8'h35;
  localparam logic [7:0] DSR_OFF_WWD_ERR_CNT = 8'h36;
  localparam logic [7:0] DSR_OFF_FWD_PASS_CNT = 8'h37;
  localparam logic [7:0] DSR_OFF_FWD_QUEST = 8'h38;
  localparam logic [7:0] DSR_OFF_TEC = 8'h39;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DSR_RST_ZERO = 8'h00;
  localparam logic [7:0] DSR_RST_WD_CNT = 8'h30;
  localparam logic [7:0] DSR_RST_FWD_QUEST = 8'h30;
  localparam logic [7:0] DSR_UNMAPPED_DATA = 8'h00;

  // ----------------------------------------------------------------
  // two-bit diagnosis codes
  // ----------------------------------------------------------------
  localparam logic [1:0] DSR_CODE_NONE = 2'h0;
  localparam logic [1:0] DSR_CODE_SHORT_BAT = 2'h1;
  localparam logic [1:0] DSR_CODE_OPEN = 2'h2;
  localparam logic [1:0] DSR_CODE_SHORT_GND = 2'h3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DSR_SNS_OL_VALID = 4;
  localparam int DSR_SNS_SC_VALID = 3;
  localparam int DSR_SNS_OPEN = 2;
  localparam int DSR_SNS_SHORT_BAT = 1;
  localparam int DSR_SNS_SHORT_GND = 0;
  localparam int DSR_MEAS_VALID = 7;
  localparam int DSR_MEAS_W = 7;
  localparam int DSR_COMM_LIN_OT = 5;
  localparam int DSR_COMM_CAN_OT = 4;
  localparam int DSR_COMM_CAN_TXTO = 3;
  localparam int DSR_COMM_CAN_CLAMP = 2;
  localparam int DSR_COMM_FRAME = 1;
  localparam int DSR_COMM_TIMEOUT = 0;
  localparam int DSR_OV_W = 6;
  localparam int DSR_BRI_PAIR2_OT = 5;
  localparam int DSR_BRI_PAIR1_OT = 4;
  localparam int DSR_BRI_OC_W = 4;
  localparam int DSR_WD_TEC_RES = 6;
  localparam int DSR_WD_FWD_RES = 5;
  localparam int DSR_WD_WWD_RES = 4;
  localparam int DSR_WD_FWD_CUR = 3;
  localparam int DSR_WD_FWD_PREV = 2;
  localparam int DSR_WD_WWD_EARLY = 1;
  localparam int DSR_WD_WWD_TO = 0;
  localparam int DSR_OP_EOT_WAKE = 7;
  localparam int DSR_OP_CAN_WAKE = 6;
  localparam int DSR_OP_INT_WAKE = 5;
  localparam int DSR_OP_SUPERVISION = 4;
  localparam int DSR_OP_MAIN_RELAY = 3;
  localparam int DSR_OP_AFTERRUN = 2;
  localparam int DSR_OP_WAKE_PIN = 1;
  localparam int DSR_OP_KEY_PIN = 0;
  localparam int DSR_RC_LOCK = 7;
  localparam int DSR_RC_OE = 6;
  localparam int DSR_RC_CAUSE_W = 6;
  localparam int DSR_CNT_W = 6;
  localparam int DSR_RESP_LSB = 4;
  localparam int DSR_RESP_W = 2;
  localparam int DSR_QUEST_W = 4;
  localparam int DSR_EOT_W = 24;

endpackage

/* design/dsr_fault_if.sv */
`timescale 1ns/1ps
// fault indications of one output and the code that sums them up
interface dsr_fault_if;
  logic short_bat;
  logic overtemp;
  logic open_load;
  logic short_gnd;
  logic [1:0] code;

  modport enc
  (
    input short_bat,
    input overtemp,
    input open_load,
    input short_gnd,
    output code
  );

  modport src
  (
    output short_bat,
    output overtemp,
    output open_load,
    output short_gnd,
    input code
  );
endinterface

/* design/dsr_fault_enc.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// two-bit fault encoder for one output
// ------------------------------------------------------------------
module dsr_fault_enc
  import dsr_pkg::*;
#(
  parameter bit HAS_DFB = 1'b0
)
(
  dsr_fault_if.enc port
);

  // drain feedback outputs report short to battery only
  logic bat_hit;
  assign bat_hit = port.short_bat | (port.overtemp & ~HAS_DFB);

  // short to battery wins, then short to ground, then open load
  always_comb
  begin
    if (bat_hit)
    begin
      port.code = DSR_CODE_SHORT_BAT;
    end
    else if (port.short_gnd)
    begin
      port.code = DSR_CODE_SHORT_GND;
    end
    else if (port.open_load)
    begin
      port.code = DSR_CODE_OPEN;
    end
    else
    begin
      port.code = DSR_CODE_NONE;
    end
  end

endmodule

/* design/dsr_diag_status_bank.sv */
`timescale 1ns/1ps
// Behaviour
// - sensor flags: open-load valid bit4, short valid bit3, open/bat/gnd bits 2..0.
// - sensor measurement value bits 6:0, valid at bit 7, zero after reset.
// - comm faults bits 5..0: LIN OT, CAN OT, TX timeout, clamp, frame, timeout.
// - general output codes: 0 none, 1 bat/overtemp, 2 open off, 3 gnd off.
// - outputs 8 to 13 use code 1 for short to battery only.
// - four outputs per register, lowest in bits 1:0, outputs 1 to 20.
// - overvoltage flag per output 8 to 13, output 8 at bit 0.
// - bridge outputs 21 to 24 off diagnosis, output 21 in bits 1:0.
// - bridge pair overtemp bits 5 and 4, overcurrent outputs 24..21 bits 3..0.
// - ignition codes: 0 none, 1 bat/overtemp, 2 open, 3 gnd on.
// - watchdog reset causes: total error bit6, functional bit5, window bit4.
// - functional response error current sequence bit3, previous sequence bit2.
// - window service too early bit1, window timeout bit0.
// - engine off count 24 bits in three readable bytes, reset zero.
// - wake sources: engine off timer bit7, CAN bit6, combined internal bit5.
// - main relay on at bit3, afterrun mode at bit2.
// - supervision pin level bit4, wake pin bit1, key pin bit0.
// - configuration lock at bit7, global output enable at bit6.
// - reset cause flags bits 5..0, valid only without internal power-on reset.
// - window error and functional pass counters, 6 bits, reset 110000.
// - response counter bits 5:4 reset 11, question bits 3:0 reset zero.
// - total error counter, 6 bits, reset 110000.
module dsr_diag_status_bank
  import dsr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic [DSR_ADDR_W-1:0] addr,
  output logic [DSR_DATA_W-1:0] rd_data_q,
  output logic rd_valid_q,
  output logic wr_refused_q,
  input wire logic sensor_openload_data_valid,
  input wire logic sensor_short_data_valid,
  input wire logic sensor_open_load,
  input wire logic sensor_short_bat,
  input wire logic sensor_short_gnd,
  input wire logic sensor_adc_data_valid,
  input wire logic [DSR_MEAS_W-1:0] sensor_measurement_value,
  input wire logic lin_overtemperature,
  input wire logic can_overtemperature,
  input wire logic can_transmit_dominant_timeout,
  input wire logic can_bus_dominant_clamp,
  input wire logic serial_frame_error,
  input wire logic serial_channel_timeout,
  input wire logic [DSR_OUT_COUNT-1:0] out_short_bat,
  input wire logic [DSR_OUT_COUNT-1:0] out_overtemp,
  input wire logic [DSR_OUT_COUNT-1:0] out_open_off,
  input wire logic [DSR_OUT_COUNT-1:0] out_short_gnd_off,
  input wire logic [DSR_OV_W-1:0] out_overvoltage,
  input wire logic [DSR_DATA_W-1:0] bridge_off_code,
  input wire logic [1:0] bridge_pair_overtemp,
  input wire logic [DSR_BRI_OC_W-1:0] bridge_overcurrent,
  input wire logic [DSR_IGN_COUNT-1:0] ign_short_bat,
  input wire logic [DSR_IGN_COUNT-1:0] ign_overtemp,
  input wire logic [DSR_IGN_COUNT-1:0] ign_open_load,
  input wire logic [DSR_IGN_COUNT-1:0] ign_short_gnd_on,
  input wire logic total_error_reset_flag,
  input wire logic functional_wd_reset_flag,
  input wire logic window_wd_reset_flag,
  input wire logic functional_wd_current_response_error,
  input wire logic functional_wd_previous_response_error,
  input wire logic window_wd_early_service,
  input wire logic window_wd_timeout,
  input wire logic [DSR_EOT_W-1:0] engine_off_count,
  input wire logic engine_off_timer_wake,
  input wire logic can_bus_wake,
  input wire logic combined_internal_wake,
  input wire logic supervision_pin,
  input wire logic main_relay_on,
  input wire logic afterrun_mode_flag,
  input wire logic wake_pin_level,
  input wire logic key_pin_level,
  input wire logic config_locked,
  input wire logic global_output_enable,
  input wire logic engine_off_timer_reset_flag,
  input wire logic external_pin_reset_flag,
  input wire logic supply_overvoltage_reset_flag,
  input wire logic supply_undervoltage_reset_flag,
  input wire logic watchdog_reset_flag,
  input wire logic afterrun_reset_flag,
  input wire logic internal_por_seen,
  input wire logic [DSR_CNT_W-1:0] window_wd_error_count,
  input wire logic [DSR_CNT_W-1:0] functional_wd_pass_count,
  input wire logic [DSR_RESP_W-1:0] functional_wd_response_count,
  input wire logic [DSR_QUEST_W-1:0] functional_wd_question,
  input wire logic [DSR_CNT_W-1:0] total_error_count
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0] out_code [DSR_OUT_COUNT];
  logic [1:0] ign_code [DSR_IGN_COUNT];
  logic [DSR_SYNC_PINS-1:0] pin_meta_q;
  logic [DSR_SYNC_PINS-1:0] pin_sync_q;
  logic [DSR_DATA_W-1:0] sensor_flags_d;
  logic [DSR_DATA_W-1:0] sensor_flags_q;
  logic [DSR_DATA_W-1:0] sensor_meas_d;
  logic [DSR_DATA_W-1:0] sensor_meas_q;
  logic [DSR_DATA_W-1:0] comm_faults_d;
  logic [DSR_DATA_W-1:0] comm_faults_q;
  logic [DSR_DATA_W-1:0] out_diag_d [DSR_OUT_REGS];
  logic [DSR_DATA_W-1:0] out_diag_q [DSR_OUT_REGS];
  logic [DSR_DATA_W-1:0] out_ov_q;
  logic [DSR_DATA_W-1:0] bridge_off_q;
  logic [DSR_DATA_W-1:0] bridge_fault_d;
  logic [DSR_DATA_W-1:0] bridge_fault_q;
  logic [DSR_DATA_W-1:0] ign_diag_d;
  logic [DSR_DATA_W-1:0] ign_diag_q;
  logic [DSR_DATA_W-1:0] wd_faults_d;
  logic [DSR_DATA_W-1:0] wd_faults_q;
  logic [DSR_EOT_W-1:0] eot_count_q;
  logic [DSR_DATA_W-1:0] op_state_d;
  logic [DSR_DATA_W-1:0] op_state_q;
  logic [DSR_DATA_W-1:0] reset_cause_d;
  logic [DSR_DATA_W-1:0] reset_cause_q;
  logic [DSR_DATA_W-1:0] wwd_err_cnt_q;
  logic [DSR_DATA_W-1:0] fwd_pass_cnt_q;
  logic [DSR_DATA_W-1:0] fwd_quest_q;
  logic [DSR_DATA_W-1:0] tec_q;
  logic [DSR_DATA_W-1:0] rd_mux;

  // ----------------------------------------------------------------
  // fault encoders for outputs 1 to 20 and ignition 1 to 4
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < DSR_OUT_COUNT; gi++)
  begin : g_out
    dsr_fault_if fif ();
    assign fif.short_bat = out_short_bat[gi];
    assign fif.overtemp = out_overtemp[gi];
    assign fif.open_load = out_open_off[gi];
    assign fif.short_gnd = out_short_gnd_off[gi];
    // drain feedback outputs take the reduced code set
    dsr_fault_enc #(
      .HAS_DFB((gi + 1 >= DSR_DFB_FIRST) && (gi + 1 <= DSR_DFB_LAST))
    ) u_enc (
      .port(fif.enc)
    );
    assign out_code[gi] = fif.code;
  end

  for (genvar gi = 0; gi < DSR_IGN_COUNT; gi++)
  begin : g_ign
    dsr_fault_if fif ();
    assign fif.short_bat = ign_short_bat[gi];
    assign fif.overtemp = ign_overtemp[gi];
    assign fif.open_load = ign_open_load[gi];
    assign fif.short_gnd = ign_short_gnd_on[gi];
    dsr_fault_enc #(
      .HAS_DFB(1'b0)
    ) u_enc (
      .port(fif.enc)
    );
    assign ign_code[gi] = fif.code;
  end

  // ----------------------------------------------------------------
  // pin synchronisers: supervision, wake, key
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end
    else
    begin
      pin_meta_q <= {supervision_pin, wake_pin_level, key_pin_level};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // field packing
  // ----------------------------------------------------------------
  // sensor, communication and bridge fields
  always_comb
  begin
    sensor_flags_d = '0;
    sensor_flags_d[DSR_SNS_OL_VALID] = sensor_openload_data_valid;
    sensor_flags_d[DSR_SNS_SC_VALID] = sensor_short_data_valid;
    sensor_flags_d[DSR_SNS_OPEN] = sensor_open_load;
    sensor_flags_d[DSR_SNS_SHORT_BAT] = sensor_short_bat;
    sensor_flags_d[DSR_SNS_SHORT_GND] = sensor_short_gnd;
    sensor_meas_d = {sensor_adc_data_valid, sensor_measurement_value};
    comm_faults_d = '0;
    comm_faults_d[DSR_COMM_LIN_OT] = lin_overtemperature;
    comm_faults_d[DSR_COMM_CAN_OT] = can_overtemperature;
    comm_faults_d[DSR_COMM_CAN_TXTO] = can_transmit_dominant_timeout;
    comm_faults_d[DSR_COMM_CAN_CLAMP] = can_bus_dominant_clamp;
    comm_faults_d[DSR_COMM_FRAME] = serial_frame_error;
    comm_faults_d[DSR_COMM_TIMEOUT] = serial_channel_timeout;
    bridge_fault_d = '0;
    bridge_fault_d[DSR_BRI_PAIR2_OT] = bridge_pair_overtemp[1];
    bridge_fault_d[DSR_BRI_PAIR1_OT] = bridge_pair_overtemp[0];
    bridge_fault_d[DSR_BRI_OC_W-1:0] = bridge_overcurrent;
  end

  // four two-bit fields per output register, lowest output in bits 1:0
  always_comb
  begin
    for (int r = 0; r < DSR_OUT_REGS; r++)
    begin
      out_diag_d[r] = '0;
      for (int f = 0; f < DSR_FIELDS_PER_REG; f++)
      begin
        out_diag_d[r][f*DSR_FIELD_W +: DSR_FIELD_W] =
          out_code[r*DSR_FIELDS_PER_REG + f];
      end
    end
    ign_diag_d = '0;
    for (int f = 0; f < DSR_IGN_COUNT; f++)
    begin
      ign_diag_d[f*DSR_FIELD_W +: DSR_FIELD_W] = ign_code[f];
    end
  end

  // watchdog, operating state and reset cause fields
  always_comb
  begin
    wd_faults_d = '0;
    wd_faults_d[DSR_WD_TEC_RES] = total_error_reset_flag;
    wd_faults_d[DSR_WD_FWD_RES] = functional_wd_reset_flag;
    wd_faults_d[DSR_WD_WWD_RES] = window_wd_reset_flag;
    wd_faults_d[DSR_WD_FWD_CUR] = functional_wd_current_response_error;
    wd_faults_d[DSR_WD_FWD_PREV] = functional_wd_previous_response_error;
    wd_faults_d[DSR_WD_WWD_EARLY] = window_wd_early_service;
    wd_faults_d[DSR_WD_WWD_TO] = window_wd_timeout;
    op_state_d = '0;
    op_state_d[DSR_OP_EOT_WAKE] = engine_off_timer_wake;
    op_state_d[DSR_OP_CAN_WAKE] = can_bus_wake;
    op_state_d[DSR_OP_INT_WAKE] = combined_internal_wake;
    op_state_d[DSR_OP_SUPERVISION] = pin_sync_q[2];
    op_state_d[DSR_OP_MAIN_RELAY] = main_relay_on;
    op_state_d[DSR_OP_AFTERRUN] = afterrun_mode_flag;
    op_state_d[DSR_OP_WAKE_PIN] = pin_sync_q[1];
    op_state_d[DSR_OP_KEY_PIN] = pin_sync_q[0];
    reset_cause_d = '0;
    reset_cause_d[DSR_RC_LOCK] = config_locked;
    reset_cause_d[DSR_RC_OE] = global_output_enable;
    // cause flags hidden while an internal power-on reset is on record
    if (!internal_por_seen)
    begin
      reset_cause_d[DSR_RC_CAUSE_W-1:0] = {engine_off_timer_reset_flag,
        external_pin_reset_flag, supply_overvoltage_reset_flag,
        supply_undervoltage_reset_flag, watchdog_reset_flag,
        afterrun_reset_flag};
    end
  end

  // ----------------------------------------------------------------
  // snapshot registers, refreshed every clock from the sources
  // ----------------------------------------------------------------
  // diagnosis snapshots
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sensor_flags_q <= DSR_RST_ZERO;
      sensor_meas_q <= DSR_RST_ZERO;
      comm_faults_q <= DSR_RST_ZERO;
      out_ov_q <= DSR_RST_ZERO;
      bridge_off_q <= DSR_RST_ZERO;
      bridge_fault_q <= DSR_RST_ZERO;
      ign_diag_q <= DSR_RST_ZERO;
      wd_faults_q <= DSR_RST_ZERO;
      for (int r = 0; r < DSR_OUT_REGS; r++)
      begin
        out_diag_q[r] <= DSR_RST_ZERO;
      end
    end
    else
    begin
      sensor_flags_q <= sensor_flags_d;
      sensor_meas_q <= sensor_meas_d;
      comm_faults_q <= comm_faults_d;
      out_ov_q <= {{(DSR_DATA_W-DSR_OV_W){1'b0}}, out_overvoltage};
      bridge_off_q <= bridge_off_code;
      bridge_fault_q <= bridge_fault_d;
      ign_diag_q <= ign_diag_d;
      wd_faults_q <= wd_faults_d;
      for (int r = 0; r < DSR_OUT_REGS; r++)
      begin
        out_diag_q[r] <= out_diag_d[r];
      end
    end
  end

  // status and counter snapshots
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      eot_count_q <= '0;
      op_state_q <= DSR_RST_ZERO;
      reset_cause_q <= DSR_RST_ZERO;
      wwd_err_cnt_q <= DSR_RST_WD_CNT;
      fwd_pass_cnt_q <= DSR_RST_WD_CNT;
      fwd_quest_q <= DSR_RST_FWD_QUEST;
      tec_q <= DSR_RST_WD_CNT;
    end
    else
    begin
      eot_count_q <= engine_off_count;
      op_state_q <= op_state_d;
      reset_cause_q <= reset_cause_d;
      wwd_err_cnt_q <= {2'h0, window_wd_error_count};
      fwd_pass_cnt_q <= {2'h0, functional_wd_pass_count};
      fwd_quest_q <= {2'h0, functional_wd_response_count,
        functional_wd_question};
      tec_q <= {2'h0, total_error_count};
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  always_comb
  begin
    case (addr)
      DSR_OFF_SENSOR_FLAGS: rd_mux = sensor_flags_q;
      DSR_OFF_SENSOR_MEAS: rd_mux = sensor_meas_q;
      DSR_OFF_COMM_FAULTS: rd_mux = comm_faults_q;
      DSR_OFF_OUT_1_4: rd_mux = out_diag_q[0];
      DSR_OFF_OUT_5_8: rd_mux = out_diag_q[1];
      DSR_OFF_OUT_9_12: rd_mux = out_diag_q[2];
      DSR_OFF_OUT_13_16: rd_mux = out_diag_q[3];
      DSR_OFF_OUT_17_20: rd_mux = out_diag_q[4];
      DSR_OFF_OUT_OV: rd_mux = out_ov_q;
      DSR_OFF_BRIDGE_OFF: rd_mux = bridge_off_q;
      DSR_OFF_BRIDGE_FAULT: rd_mux = bridge_fault_q;
      DSR_OFF_IGN_DIAG: rd_mux = ign_diag_q;
      DSR_OFF_WD_FAULTS: rd_mux = wd_faults_q;
      DSR_OFF_EOT_LOW: rd_mux = eot_count_q[7:0];
      DSR_OFF_EOT_MID: rd_mux = eot_count_q[15:8];
      DSR_OFF_EOT_HIGH: rd_mux = eot_count_q[23:16];
      DSR_OFF_OP_STATE: rd_mux = op_state_q;
      DSR_OFF_RESET_CAUSE: rd_mux = reset_cause_q;
      DSR_OFF_WWD_ERR_CNT: rd_mux = wwd_err_cnt_q;
      DSR_OFF_FWD_PASS_CNT: rd_mux = fwd_pass_cnt_q;
      DSR_OFF_FWD_QUEST: rd_mux = fwd_quest_q;
      DSR_OFF_TEC: rd_mux = tec_q;
      default: rd_mux = DSR_UNMAPPED_DATA;
    endcase
  end

  // ----------------------------------------------------------------
  // access port: read answer and write refusal
  // ----------------------------------------------------------------
  // read data holds until the next read
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= rd_req;
      if (rd_req)
      begin
        rd_data_q <= rd_mux;
      end
    end
  end

  // writes reach no storage; they are only acknowledged as refused
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wr_refused_q <= 1'b0;
    end
    else
    begin
      wr_refused_q <= wr_req;
    end
  end

endmodule

/* test/dsr_asserts.sv */
`timescale 1ns/1ps
module dsr_asserts
  import dsr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic [DSR_ADDR_W-1:0] addr,
  input wire logic [DSR_DATA_W-1:0] rd_data_q,
  input wire logic rd_valid_q,
  input wire logic wr_refused_q,
  input wire logic [DSR_EOT_W-1:0] engine_off_count,
  input wire logic [DSR_DATA_W-1:0] bridge_off_code
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // register port handshake
  // ----------------------------------------------------------------
  sequence s_rd(logic [7:0] a);
    rd_req && addr == a;
  endsequence
  property p_rd_ack; rd_req |=> rd_valid_q; endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
  property p_rd_quiet; !rd_req |=> !rd_valid_q && $stable(rd_data_q); endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data moved");
  property p_wr_ack; wr_req |=> wr_refused_q; endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write not refused");
  property p_wr_quiet; !wr_req |=> !wr_refused_q; endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("stray refusal");
  // ----------------------------------------------------------------
  // snapshot contents, taken one edge before the read
  // ----------------------------------------------------------------
  property p_eot_lo; s_rd(8'h31) |=> rd_data_q == $past(engine_off_count[7:0], 2); endproperty
  a_eot_lo: assert property (p_eot_lo) else $error("count low byte wrong");
  property p_eot_mid; s_rd(8'h32) |=> rd_data_q == $past(engine_off_count[15:8], 2); endproperty
  a_eot_mid: assert property (p_eot_mid) else $error("count mid byte wrong");
  property p_eot_hi; s_rd(8'h33) |=> rd_data_q == $past(engine_off_count[23:16], 2); endproperty
  a_eot_hi: assert property (p_eot_hi) else $error("count high byte wrong");
  property p_bri; s_rd(8'h2b) |=> rd_data_q == $past(bridge_off_code, 2); endproperty
  a_bri: assert property (p_bri) else $error("bridge codes wrong");
endmodule

/* test/dsr_host_model.sv */
`timescale 1ns/1ps
module dsr_host_model
  import dsr_pkg::*;
(
  input wire logic mclk,
  output logic rd_req,
  output logic wr_req,
  output logic [DSR_ADDR_W-1:0] addr
);
  // idle bus at time zero
  initial
  begin
    rd_req = 1'b0;
    wr_req = 1'b0;
    addr = 8'h00;
  end
  // one request cycle; an idle address is scrambled so nothing relies on it
  task automatic req(input logic r, input logic w, input logic [7:0] a);
    @(negedge mclk);
    rd_req = r;
    wr_req = w;
    addr = (r | w) ? a : ~addr;
  endtask
endmodule

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic rd_req, wr_req, rd_valid_q, wr_refused_q;
  logic wr_d = 1'b0;
  logic [7:0] addr, rd_data_q;
  logic [223:0] rv = '0;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  always #4 mclk = ~mclk;
  dsr_host_model host (.mclk(mclk), .rd_req(rd_req), .wr_req(wr_req), .addr(addr));
  dsr_diag_status_bank dut (.mclk(mclk), .rst_n(rst_n), .rd_req(rd_req), .wr_req(wr_req),
    .addr(addr), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .wr_refused_q(wr_refused_q),
    .sensor_openload_data_valid(rv[4]), .sensor_short_data_valid(rv[3]),
    .sensor_open_load(rv[2]), .sensor_short_bat(rv[1]), .sensor_short_gnd(rv[0]),
    .sensor_adc_data_valid(rv[12]), .sensor_measurement_value(rv[11:5]),
    .lin_overtemperature(rv[18]), .can_overtemperature(rv[17]),
    .can_transmit_dominant_timeout(rv[16]), .can_bus_dominant_clamp(rv[15]),
    .serial_frame_error(rv[14]), .serial_channel_timeout(rv[13]),
    .out_short_bat(rv[38:19]), .out_overtemp(rv[58:39]), .out_open_off(rv[78:59]),
    .out_short_gnd_off(rv[98:79]), .out_overvoltage(rv[104:99]), .bridge_off_code(rv[112:105]),
    .bridge_pair_overtemp(rv[118:117]), .bridge_overcurrent(rv[116:113]),
    .ign_short_bat(rv[122:119]), .ign_overtemp(rv[126:123]), .ign_open_load(rv[130:127]),
    .ign_short_gnd_on(rv[134:131]), .total_error_reset_flag(rv[141]),
    .functional_wd_reset_flag(rv[140]), .window_wd_reset_flag(rv[139]),
    .functional_wd_current_response_error(rv[138]),
    .functional_wd_previous_response_error(rv[137]),
    .window_wd_early_service(rv[136]), .window_wd_timeout(rv[135]),
    .engine_off_count(rv[165:142]), .engine_off_timer_wake(rv[173]), .can_bus_wake(rv[172]),
    .combined_internal_wake(rv[171]), .supervision_pin(rv[170]), .main_relay_on(rv[169]),
    .afterrun_mode_flag(rv[168]), .wake_pin_level(rv[167]), .key_pin_level(rv[166]),
    .config_locked(rv[175]), .global_output_enable(rv[174]),
    .engine_off_timer_reset_flag(rv[181]), .external_pin_reset_flag(rv[180]),
    .supply_overvoltage_reset_flag(rv[179]), .supply_undervoltage_reset_flag(rv[178]),
    .watchdog_reset_flag(rv[177]), .afterrun_reset_flag(rv[176]), .internal_por_seen(rv[182]),
    .window_wd_error_count(rv[188:183]), .functional_wd_pass_count(rv[194:189]),
    .functional_wd_response_count(rv[200:199]), .functional_wd_question(rv[198:195]),
    .total_error_count(rv[206:201]));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want)
    begin
      miscompares++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // two-bit code, battery short or overtemp first, then ground, then open
  function automatic logic [1:0] code(input logic b, input logic t, input logic o,
    input logic g);
    return (b | t) ? 2'h1 : g ? 2'h3 : o ? 2'h2 : 2'h0;
  endfunction
  // expected register contents from the current stimulus
  function automatic logic [7:0] expect_reg(input logic [7:0] a);
    logic [7:0] r;
    int n;
    r = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      n = 4 * (a - 8'h25) + i;
      if (a >= 8'h25 && a <= 8'h29)
        r[2*i +: 2] = code(rv[19+n], rv[39+n] && (n < 7 || n > 12),
          rv[59+n], rv[79+n]);
      if (a == 8'h2d)
        r[2*i +: 2] = code(rv[119+i], rv[123+i], rv[127+i], rv[131+i]);
    end
    case (a)
      8'h22: r = {3'h0, rv[4:0]};
      8'h23: r = rv[12:5];
      8'h24: r = {2'h0, rv[18:13]};
      8'h2a: r = {2'h0, rv[104:99]};
      8'h2b: r = rv[112:105];
      8'h2c: r = {2'h0, rv[118:113]};
      8'h2e: r = {1'h0, rv[141:135]};
      8'h31: r = rv[149:142];
      8'h32: r = rv[157:150];
      8'h33: r = rv[165:158];
      8'h34: r = rv[173:166];
      8'h35: r = {rv[175:174], rv[182] ? 6'h00 : rv[181:176]};
      8'h36: r = {2'h0, rv[188:183]};
      8'h37: r = {2'h0, rv[194:189]};
      8'h38: r = {2'h0, rv[200:195]};
      8'h39: r = {2'h0, rv[206:201]};
      default: ;
    endcase
    return r;
  endfunction
  // back-to-back reads over the map and its gaps, writes on odd addresses
  task automatic sweep();
    for (int a = 8'h21; a <= 8'h3a; a++)
    begin
      host.req(1'b1, a[0], a[7:0]);
      exp_q.push_back(expect_reg(a[7:0]));
    end
    host.req(1'b0, 1'b0, 8'h00);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(negedge mclk);
    check(rd_data_q, 8'h00);
    check({7'h0, rd_valid_q}, 8'h00);
    rst_n <= 1'b1;
  endtask
  // refusal follows each write; answered reads match the oldest note
  always @(posedge mclk)
  begin
    wr_d <= wr_req & rst_n;
    cycles <= cycles + 1;
  end
  always @(negedge mclk)
  begin
    if (cycles > 1000)
    begin
      miscompares++;
      report_and_stop();
    end
    if (rst_n === 1'b1)
    begin
      check({7'h0, wr_refused_q}, {7'h0, wr_d});
      if (rd_valid_q === 1'b1)
        check(rd_data_q, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end
  end
  initial
  begin
    void'($urandom(33));
    do_reset();
    for (int k = 0; k < 8; k++)
    begin
      @(negedge mclk);
      rv = (k == 0) ? '1 : {$urandom, $urandom, $urandom, $urandom, $urandom,
        $urandom, $urandom};
      repeat (4) @(negedge mclk);
      sweep();
      if (k == 3)
        do_reset();
      $display("test %0d done", k);
    end
    host.req(1'b0, 1'b0, 8'h00);
    check(8'(exp_q.size()), 8'h00);
    report_and_stop();
  end
endmodule
bind dsr_diag_status_bank dsr_asserts chk (.*);
